// File: hw/crtt_map.vh
// Register map, field positions, reset values and timing counts of the display timing unit
`ifndef CRTT_MAP_VH
`define CRTT_MAP_VH
`define CRTT_MODE_ADDR 32'h01803400
`define CRTT_FWIN_ADDR 32'h01803414
`define CRTT_VBP_ADDR 32'h01803418
`define CRTT_VERTICAL_DISPLAY_TOTAL_ADDR 32'h0180341c
`define CRTT_HORIZONTAL_LINE_TOTAL_ADDR 32'h01803420
`define CRTT_VERTICAL_LINE_TOTAL_ADDR 32'h01803424
`define CRTT_HSTART_ADDR 32'h01803428
`define CRTT_BANK0_ADDR 32'h0180342c
`define CRTT_BANK1_ADDR 32'h01803430
`define CRTT_KEY_ADDR 32'h01803434
`define CRTT_P0X_ADDR 32'h01803438
`define CRTT_P0Y_ADDR 32'h0180343c
`define CRTT_P1X_ADDR 32'h01803440
`define CRTT_P1Y_ADDR 32'h01803444
`define CRTT_PPOL_ADDR 32'h01803448
`define CRTT_PROT_LO 32'h01803404
`define CRTT_PROT_HI 32'h01803424
`define CRTT_MODE_WMASK 32'h000003cb
`define CRTT_FWIN_WMASK 32'h00007f3f
`define CRTT_VBP_WMASK 32'h000000ff
`define CRTT_VERTICAL_DISPLAY_TOTAL_WMASK 32'h000001ff
`define CRTT_HORIZONTAL_LINE_TOTAL_WMASK 32'h00001400
`define CRTT_VERTICAL_LINE_TOTAL_WMASK 32'h00000800
`define CRTT_HSTART_WMASK 32'h000003ff
`define CRTT_BANK0_WMASK 32'h00007ffd
`define CRTT_BANK1_WMASK 32'h00007fff
`define CRTT_KEY_WMASK 32'h0000ffff
`define CRTT_PPOL_WMASK 32'h00000003
`define CRTT_MODE_PROT_BIT 8
`define CRTT_MODE_625_BIT 7
`define CRTT_FWIN_SRC_BIT 14
`define CRTT_HORIZONTAL_LINE_TOTAL_EN_BIT 10
`define CRTT_HORIZONTAL_LINE_TOTAL_TEST_BIT 12
`define CRTT_VERTICAL_LINE_TOTAL_EN_BIT 11
`define CRTT_BANK_FLIP_BIT 0
`define CRTT_BANK_BUF_BIT 1
`define CRTT_BANK_NONIL_BIT 0
`define CRTT_REG_RESET 32'h00000000
`define CRTT_HORIZONTAL_LINE_TOTAL_AUTO_525 10'h1c6
`define CRTT_HORIZONTAL_LINE_TOTAL_AUTO_625 10'h237
`define CRTT_VERTICAL_LINE_TOTAL_AUTO_525 11'h1f9
`define CRTT_VERTICAL_LINE_TOTAL_AUTO_625 11'h25e
`define CRTT_VERTICAL_LINE_TOTAL_BASE 11'h009
`define CRTT_CSYNC_WIDTH 12'h040
`define CRTT_CSYNC_TEST_WIDTH 12'h002
`define CRTT_VSYNC_LINES 11'h003
`define CRTT_WIDE_PIXELS 12'h200
`define CRTT_RESP_OKAY 2'b00
`define CRTT_RESP_SLVERR 2'b10
`endif

// File: hw/crtt_timing.v
// Display timing unit: AXI4-Lite registers, raster counters, sync, overlay key, light pens
`timescale 1ns/1ps
`default_nettype none
`include "crtt_map.vh"

module crtt_timing (
    input wire aclk,
    input wire aresetn,
    input wire ce,
    input wire [31:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [31:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire sync_even_field,
    input wire sep_even_field,
    input wire ext_video_ok,
    input wire [15:0] pixel_data,
    input wire pixel_valid,
    input wire [1:0] pen_strobe,
    output wire csync_n,
    output wire display_en,
    output wire even_field,
    output wire overlay,
    output wire vflip_en,
    output wire [22:0] frame_addr
);

////////////////////////////////////////////////////////////////////////////////
// Register storage

reg [31:0] mode_r, fwin_r, vbp_r, vertical_display_total_r, horizontal_line_total_r, vertical_line_total_r, hstart_r;
reg [31:0] bank0_r, bank1_r, key_r, ppol_r;
reg [10:0] pen_x_r [0:1];
reg [8:0] pen_y_r [0:1];
reg [1:0] pen_prev_r;

reg awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
reg aw_got_r, w_got_r;
reg [31:0] aw_addr_r, w_data_r, rdata_r;
reg [3:0] w_strb_r;
reg [1:0] bresp_r, rresp_r;

reg [11:0] hcnt_r;
reg [10:0] vcnt_r;
reg csync_n_r, disp_r, even_r, ovl_r, flip_r;
reg [22:0] faddr_r;

// Register index; 4'hf marks an unmapped address
function [3:0] reg_sel;
    input [31:0] a;
    begin
        case (a)
            `CRTT_MODE_ADDR: reg_sel = 4'h0;
            `CRTT_FWIN_ADDR: reg_sel = 4'h1;
            `CRTT_VBP_ADDR: reg_sel = 4'h2;
            `CRTT_VERTICAL_DISPLAY_TOTAL_ADDR: reg_sel = 4'h3;
            `CRTT_HORIZONTAL_LINE_TOTAL_ADDR: reg_sel = 4'h4;
            `CRTT_VERTICAL_LINE_TOTAL_ADDR: reg_sel = 4'h5;
            `CRTT_HSTART_ADDR: reg_sel = 4'h6;
            `CRTT_BANK0_ADDR: reg_sel = 4'h7;
            `CRTT_BANK1_ADDR: reg_sel = 4'h8;
            `CRTT_KEY_ADDR: reg_sel = 4'h9;
            `CRTT_P0X_ADDR: reg_sel = 4'ha;
            `CRTT_P0Y_ADDR: reg_sel = 4'hb;
            `CRTT_P1X_ADDR: reg_sel = 4'hc;
            `CRTT_P1Y_ADDR: reg_sel = 4'hd;
            `CRTT_PPOL_ADDR: reg_sel = 4'he;
            default: reg_sel = 4'hf;
        endcase
    end
endfunction

// Byte-lane merge limited to writable bits
function [31:0] merge;
    input [31:0] old;
    input [31:0] d;
    input [3:0] s;
    input [31:0] wm;
    reg [31:0] m;
    begin
        m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & wm;
        merge = (old & ~m) | (d & m);
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Effective timing values

wire is_625 = mode_r[`CRTT_MODE_625_BIT];
wire nonil = bank1_r[`CRTT_BANK_NONIL_BIT];
wire [9:0] horizontal_line_total_eff = horizontal_line_total_r[`CRTT_HORIZONTAL_LINE_TOTAL_EN_BIT] ? horizontal_line_total_r[9:0] :
    (is_625 ? `CRTT_HORIZONTAL_LINE_TOTAL_AUTO_625 : `CRTT_HORIZONTAL_LINE_TOTAL_AUTO_525);
wire [10:0] vertical_line_total_eff = vertical_line_total_r[`CRTT_VERTICAL_LINE_TOTAL_EN_BIT] ? vertical_line_total_r[10:0] :
    (is_625 ? `CRTT_VERTICAL_LINE_TOTAL_AUTO_625 : `CRTT_VERTICAL_LINE_TOTAL_AUTO_525);
// Line length is field plus one, doubled
wire [9:0] horizontal_line_total_inc = horizontal_line_total_eff + 10'h001;
wire [11:0] hlen = {1'b0, horizontal_line_total_inc, 1'b0};
// Lines per vsync period; one field
wire [11:0] vsum = {1'b0, vertical_line_total_eff} + 12'h001;
wire [10:0] vlines = `CRTT_VERTICAL_LINE_TOTAL_BASE + vsum[11:1];
wire [11:0] csw = horizontal_line_total_r[`CRTT_HORIZONTAL_LINE_TOTAL_TEST_BIT] ? `CRTT_CSYNC_TEST_WIDTH : `CRTT_CSYNC_WIDTH;
// Porch ends after vsync plus porch
wire [10:0] vact_lo = `CRTT_VSYNC_LINES + {3'b000, vbp_r[7:0]} + 11'h001;
wire [10:0] vact_hi = vact_lo + {2'b00, vertical_display_total_r[8:0]} + 11'h001;
wire v_act = (vcnt_r >= vact_lo) && (vcnt_r < vact_hi);
wire v_sync = vcnt_r < `CRTT_VSYNC_LINES;
wire line_end = hcnt_r == hlen - 12'h001;
wire [11:0] win_lo = {2'b00, fwin_r[5:0], 4'h0};
wire [11:0] win_hi = {2'b00, fwin_r[13:8], 4'h0};
wire in_win = (hcnt_r >= win_lo) && (hcnt_r <= win_hi);
wire fsrc = fwin_r[`CRTT_FWIN_SRC_BIT] ? sep_even_field : sync_even_field;
wire h_act = hcnt_r >= {2'b00, hstart_r[9:0]};
// Wide lines measured from start to line end
wire wide = (hlen - {2'b00, hstart_r[9:0]}) >= `CRTT_WIDE_PIXELS;
// Buffer choice per field; non-interlace always bank 0
wire bank_sel = nonil ? 1'b0 : (bank1_r[`CRTT_BANK_BUF_BIT] ? ~even_r : even_r);
wire [31:0] bank_w = bank_sel ? bank1_r : bank0_r;
wire [22:0] addr_nxt = (!nonil && wide) ? {bank_w[13:2], 11'h000} :
    {bank_w[14:2], 10'h000};
wire [1:0] pen_act = pen_strobe ^ ppol_r[1:0];

////////////////////////////////////////////////////////////////////////////////
// Raster counters and outputs

always @(posedge aclk) begin
    if (!aresetn) begin
        hcnt_r <= 12'h000;
        vcnt_r <= 11'h000;
        csync_n_r <= 1'b1;
        disp_r <= 1'b0;
        even_r <= 1'b0;
        ovl_r <= 1'b0;
        flip_r <= 1'b0;
        faddr_r <= 23'h000000;
        pen_prev_r <= 2'b00;
    end else if (ce) begin
        if (line_end || hcnt_r >= hlen) begin
            hcnt_r <= 12'h000;
            vcnt_r <= (vcnt_r >= vlines - 11'h001) ? 11'h000 : vcnt_r + 11'h001;
        end else begin
            hcnt_r <= hcnt_r + 12'h001;
        end
        // Broad pulses during vsync, short ones otherwise
        csync_n_r <= v_sync ? (hcnt_r >= hlen - csw) : (hcnt_r >= csw);
        disp_r <= v_act && h_act;
        // Field sampled only inside the window, filtering noisy sync edges
        if (in_win && v_sync)
            even_r <= fsrc;
        ovl_r <= pixel_valid && disp_r && (pixel_data == key_r[15:0]);
        flip_r <= bank0_r[`CRTT_BANK_FLIP_BIT];
        faddr_r <= addr_nxt;
        pen_prev_r <= pen_act;
    end
end

genvar gp;
generate
    for (gp = 0; gp < 2; gp = gp + 1) begin : g_pen
        // Position data has no reset value
        always @(posedge aclk) begin
            if (ce && aresetn && pen_act[gp] && !pen_prev_r[gp]) begin
                pen_x_r[gp] <= hcnt_r[10:0];
                pen_y_r[gp] <= vcnt_r[8:0];
            end
        end
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// AXI4-Lite write path

wire [3:0] wsel = reg_sel(aw_addr_r);
wire wprot = mode_r[`CRTT_MODE_PROT_BIT] && (aw_addr_r >= `CRTT_PROT_LO) &&
    (aw_addr_r <= `CRTT_PROT_HI);
wire do_wr = aw_got_r && w_got_r && !bvalid_r;

always @(posedge aclk) begin
    if (!aresetn) begin
        awready_r <= 1'b0;
        wready_r <= 1'b0;
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        aw_addr_r <= 32'h00000000;
        w_data_r <= 32'h00000000;
        w_strb_r <= 4'h0;
        bvalid_r <= 1'b0;
        bresp_r <= `CRTT_RESP_OKAY;
        mode_r <= `CRTT_REG_RESET;
        fwin_r <= `CRTT_REG_RESET;
        vbp_r <= `CRTT_REG_RESET;
        vertical_display_total_r <= `CRTT_REG_RESET;
        horizontal_line_total_r <= `CRTT_REG_RESET;
        vertical_line_total_r <= `CRTT_REG_RESET;
        hstart_r <= `CRTT_REG_RESET;
        bank0_r <= `CRTT_REG_RESET;
        bank1_r <= `CRTT_REG_RESET;
        key_r <= `CRTT_REG_RESET;
        ppol_r <= `CRTT_REG_RESET;
    end else if (ce) begin
        awready_r <= !aw_got_r && !awready_r && !bvalid_r && s_axi_awvalid;
        wready_r <= !w_got_r && !wready_r && !bvalid_r && s_axi_wvalid;
        if (awready_r && s_axi_awvalid) begin
            aw_got_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
        end
        if (wready_r && s_axi_wvalid) begin
            w_got_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
        end
        if (bvalid_r && s_axi_bready)
            bvalid_r <= 1'b0;
        if (do_wr) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r <= (wsel == 4'hf) ? `CRTT_RESP_SLVERR : `CRTT_RESP_OKAY;
            if (!wprot) begin
                case (wsel)
                    4'h0: mode_r <= merge(mode_r, w_data_r, w_strb_r, `CRTT_MODE_WMASK);
                    4'h1: fwin_r <= merge(fwin_r, w_data_r, w_strb_r, `CRTT_FWIN_WMASK);
                    4'h2: vbp_r <= merge(vbp_r, w_data_r, w_strb_r, `CRTT_VBP_WMASK);
                    4'h3: vertical_display_total_r <= merge(vertical_display_total_r, w_data_r, w_strb_r, `CRTT_VERTICAL_DISPLAY_TOTAL_WMASK);
                    4'h4: begin
                        horizontal_line_total_r <= merge(horizontal_line_total_r, w_data_r, w_strb_r,
                            `CRTT_HORIZONTAL_LINE_TOTAL_WMASK | (w_data_r[`CRTT_HORIZONTAL_LINE_TOTAL_EN_BIT] ?
                            32'h000003ff : 32'h00000000));
                    end
                    4'h5: begin
                        vertical_line_total_r <= merge(vertical_line_total_r, w_data_r, w_strb_r,
                            `CRTT_VERTICAL_LINE_TOTAL_WMASK | (w_data_r[`CRTT_VERTICAL_LINE_TOTAL_EN_BIT] ?
                            32'h000007ff : 32'h00000000));
                    end
                    4'h6: hstart_r <= merge(hstart_r, w_data_r, w_strb_r, `CRTT_HSTART_WMASK);
                    4'h7: bank0_r <= merge(bank0_r, w_data_r, w_strb_r, `CRTT_BANK0_WMASK);
                    4'h8: bank1_r <= merge(bank1_r, w_data_r, w_strb_r, `CRTT_BANK1_WMASK);
                    4'h9: key_r <= merge(key_r, w_data_r, w_strb_r, `CRTT_KEY_WMASK);
                    4'he: ppol_r <= merge(ppol_r, w_data_r, w_strb_r, `CRTT_PPOL_WMASK);
                    default: ;
                endcase
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// AXI4-Lite read path

reg [31:0] rd_mux;
always @* begin
    rd_mux = 32'h00000000;
    case (reg_sel(s_axi_araddr))
        4'h0: rd_mux = {16'h0000, csync_n_r, v_act, disp_r, ext_video_ok,
            2'b00, mode_r[9:0]};
        4'h1: rd_mux = fwin_r;
        4'h2: rd_mux = vbp_r;
        4'h3: rd_mux = vertical_display_total_r;
        4'h4: rd_mux = horizontal_line_total_r;
        4'h5: rd_mux = vertical_line_total_r;
        4'h6: rd_mux = hstart_r;
        4'h7: rd_mux = bank0_r;
        4'h8: rd_mux = bank1_r;
        4'h9: rd_mux = key_r;
        4'ha: rd_mux = {21'h000000, pen_x_r[0]};
        4'hb: rd_mux = {23'h000000, pen_y_r[0]};
        4'hc: rd_mux = {21'h000000, pen_x_r[1]};
        4'hd: rd_mux = {23'h000000, pen_y_r[1]};
        4'he: rd_mux = ppol_r;
        default: rd_mux = 32'h00000000;
    endcase
end

always @(posedge aclk) begin
    if (!aresetn) begin
        arready_r <= 1'b0;
        rvalid_r <= 1'b0;
        rdata_r <= 32'h00000000;
        rresp_r <= `CRTT_RESP_OKAY;
    end else if (ce) begin
        arready_r <= !arready_r && !rvalid_r && s_axi_arvalid;
        if (arready_r && s_axi_arvalid) begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_mux;
            rresp_r <= (reg_sel(s_axi_araddr) == 4'hf) ? `CRTT_RESP_SLVERR :
                `CRTT_RESP_OKAY;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end
end

assign s_axi_awready = awready_r;
assign s_axi_wready = wready_r;
assign s_axi_bvalid = bvalid_r;
assign s_axi_bresp = bresp_r;
assign s_axi_arready = arready_r;
assign s_axi_rvalid = rvalid_r;
assign s_axi_rdata = rdata_r;
assign s_axi_rresp = rresp_r;
assign csync_n = csync_n_r;
assign display_en = disp_r;
assign even_field = even_r;
assign overlay = ovl_r;
assign vflip_en = flip_r;
assign frame_addr = faddr_r;

endmodule // crtt_timing
`default_nettype wire

// File: bench/crtt_props_properties.sv
// Port-level checks on the display timing unit
`timescale 1ns/1ps
`default_nettype none
`include "crtt_map.vh"
module crtt_props (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [31:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire csync_n,
    input wire display_en,
    input wire overlay,
    input wire [22:0] frame_addr
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////
    sequence s_ar_hs;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_bad_rd;
        s_ar_hs ##0 (s_axi_araddr == 32'h01803500);
    endsequence
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("bvalid dropped early");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read answer not held");
    property p_aw_pulse;
        s_axi_awready |=> !s_axi_awready;
    endproperty
    a_aw_pulse: assert property (p_aw_pulse) else $error("awready longer than a cycle");
    property p_r_answer;
        s_ar_hs |=> s_axi_rvalid;
    endproperty
    a_r_answer: assert property (p_r_answer) else $error("read answer late");
    property p_r_unmapped;
        s_bad_rd |=> s_axi_rresp == `CRTT_RESP_SLVERR && s_axi_rdata == 32'h0;
    endproperty
    a_r_unmapped: assert property (p_r_unmapped) else $error("unmapped read not refused");
    property p_overlay;
        $rose(overlay) |-> $past(display_en);
    endproperty
    a_overlay: assert property (p_overlay) else $error("overlay outside display");
    property p_align;
        frame_addr[9:0] == 10'h000;
    endproperty
    a_align: assert property (p_align) else $error("frame address not aligned");
    property p_csync_min;
        $fell(csync_n) |=> !csync_n;
    endproperty
    a_csync_min: assert property (p_csync_min) else $error("sync pulse too short");
endmodule // crtt_props
bind crtt_timing crtt_props u_props (.aclk, .aresetn, .s_axi_awready, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .csync_n, .display_en, .overlay, .frame_addr);
`default_nettype wire

// File: bench/crtt_monitor.sv
// Far-side display model: pixel source, field levels, light pens
`timescale 1ns/1ps
`default_nettype none
module crtt_monitor (
    input wire logic aclk,
    input wire logic display_en,
    input wire logic [15:0] key_val,
    input wire logic key_on,
    input wire logic [1:0] pen_fire,
    input wire logic [1:0] pen_pol,
    output logic [15:0] pixel_data,
    output logic pixel_valid,
    output logic [1:0] pen_strobe,
    output logic sync_even_field,
    output logic sep_even_field,
    output logic ext_video_ok
);
    ////////////////////////////////////////
    initial begin
        pixel_data = 16'h0000;
        pixel_valid = 1'b0;
        pen_strobe = 2'b00;
    end
    assign sync_even_field = 1'b1;
    assign sep_even_field = 1'b0;
    assign ext_video_ok = 1'b1;
    always @(posedge aclk) begin
        pixel_valid <= display_en;
        // Off-key pixels never equal the key
        pixel_data <= key_on ? key_val : ~key_val;
        pen_strobe <= pen_fire ^ pen_pol;
    end
endmodule // crtt_monitor
`default_nettype wire

// File: bench/tb.sv
// Self-checking bench for the display timing unit
`timescale 1ns/1ps
`default_nettype none
`include "crtt_map.vh"
module tb;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [15:0] key_val = 16'h1234;
    logic key_on = 1'b0;
    logic [1:0] pen_fire = 2'b00, pen_pol = 2'b00;
    wire [1:0] bresp, rresp, pen_strobe;
    wire [31:0] rdata;
    wire [15:0] pixel_data;
    wire [22:0] frame_addr;
    wire awready, wready, bvalid, arready, rvalid, pixel_valid, sync_ev, sep_ev, vid_ok;
    wire csync_n, display_en, even_field, overlay, vflip_en;
    int errors = 0;
    int checks_done = 0;
    int per;
    logic [31:0] rd, rd0;
    logic [1:0] resp;
    logic [31:0] addrs [8] = '{32'h01803414, 32'h01803418, 32'h0180341c, 32'h01803428,
        32'h0180342c, 32'h01803430, 32'h01803434, 32'h01803448};
    logic [31:0] masks [8] = '{32'h7f3f, 32'hff, 32'h1ff, 32'h3ff, 32'h7ffd, 32'h7fff,
        32'hffff, 32'h3};
    always #10 aclk = ~aclk;
    crtt_timing dut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .sync_even_field(sync_ev), .sep_even_field(sep_ev), .ext_video_ok(vid_ok),
        .pixel_data(pixel_data), .pixel_valid(pixel_valid), .pen_strobe(pen_strobe),
        .csync_n(csync_n), .display_en(display_en), .even_field(even_field),
        .overlay(overlay), .vflip_en(vflip_en), .frame_addr(frame_addr));
    crtt_monitor mon (.aclk(aclk), .display_en(display_en), .key_val(key_val),
        .key_on(key_on), .pen_fire(pen_fire), .pen_pol(pen_pol), .pixel_data(pixel_data),
        .pixel_valid(pixel_valid), .pen_strobe(pen_strobe), .sync_even_field(sync_ev),
        .sep_even_field(sep_ev), .ext_video_ok(vid_ok));
    ////////////////////////////////////////
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        resp = bresp;
        bready <= 1'b0;
    endtask
    task automatic rdr(input logic [31:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    // Shortest of three rise-to-rise spans; one may straddle a frame gap
    task automatic line_len(output int p);
        int c;
        p = 100000;
        do @(posedge aclk); while (display_en);
        do @(posedge aclk); while (!display_en);
        repeat (3) begin
            c = 0;
            do begin @(posedge aclk); c++; end while (display_en);
            do begin @(posedge aclk); c++; end while (!display_en);
            if (c < p) p = c;
        end
    endtask
    task automatic wait_hi(input int n, ref logic s);
        for (int k = 0; k < n && s !== 1'b1; k++) @(posedge aclk);
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    ////////////////////////////////////////
    logic fa_ok, ov_seen;
    always @* fa_ok = (frame_addr === 23'h000800);
    always @* ov_seen = overlay;
    initial begin
        repeat (60000) @(posedge aclk);
        errors++;
        $display("watchdog expired");
        report_and_stop;
    end
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            rdr(addrs[i]);
            chk("reset value", 32'h0, rd);
        end
        $display("test reset done");
        wr(32'h0180341c, 32'h7);
        wr(32'h01803428, 32'ha);
        line_len(per);
        chk("auto line", (`CRTT_HORIZONTAL_LINE_TOTAL_AUTO_525 + 1) * 2, per);
        wr(32'h01803424, 32'h809);
        wr(32'h01803420, 32'h463);
        line_len(per);
        chk("programmed line", 32'd200, per);
        wr(32'h01803420, 32'h31);
        rdr(32'h01803420);
        chk("unenabled write", 32'h063, rd & 32'h3ff);
        line_len(per);
        chk("enable cleared line", (`CRTT_HORIZONTAL_LINE_TOTAL_AUTO_525 + 1) * 2, per);
        wr(32'h01803420, 32'h463);
        line_len(per);
        chk("reprogrammed line", 32'd200, per);
        $display("test line timing done");
        for (int i = 0; i < 8; i++) begin
            wr(addrs[i], 32'hffffffff);
            rdr(addrs[i]);
            chk("field mask", masks[i], rd);
            wr(addrs[i], 32'h0);
        end
        wr(32'h01803400, 32'h100);
        wr(32'h01803418, 32'h5a);
        rdr(32'h01803418);
        chk("protected write", 32'h0, rd);
        wr(32'h01803400, 32'h0);
        rdr(32'h01803500);
        chk("unmapped rdata", 32'h0, rd);
        chk("unmapped rresp", 32'h2, {30'h0, resp});
        wr(32'h01803500, 32'h1);
        chk("unmapped bresp", 32'h2, {30'h0, resp});
        $display("test registers done");
        wr(32'h01803430, 32'h1);
        wr(32'h0180342c, 32'h9);
        repeat (2) @(posedge aclk);
        chk("flip enable", 32'h1, {31'h0, vflip_en});
        wait_hi(4000, fa_ok);
        chk("bank0 address", 32'h800, {9'h0, frame_addr});
        wr(32'h01803434, 32'h1234);
        key_on <= 1'b1;
        wait_hi(4000, ov_seen);
        chk("overlay", 32'h1, {31'h0, overlay});
        key_on <= 1'b0;
        $display("test display done");
        wr(32'h01803448, 32'h1);
        pen_pol <= 2'b01;
        repeat (4) @(posedge aclk);
        pen_fire <= 2'b11;
        repeat (4) @(posedge aclk);
        pen_fire <= 2'b00;
        rdr(32'h01803438);
        chk("pen0 x width", 32'h0, rd & 32'hfffff800);
        chk("pen0 x latched", 32'h0, {31'h0, (^rd) === 1'bx});
        rd0 = rd;
        wr(32'h01803438, 32'hffffffff);
        rdr(32'h01803438);
        chk("pen0 x read only", rd0, rd);
        rdr(32'h01803444);
        chk("pen1 y width", 32'h0, rd & 32'hfffffe00);
        $display("test pens done");
        report_and_stop;
    end
endmodule // tb
`default_nettype wire
